// file: hw/cos_pkg.sv
package cos_pkg;

    // ****************************************
    // Register map (byte addresses = 4 x index)
    // ****************************************
    localparam logic [7:0] COS_IDX_FIRST_CTRL = 8'h1A;
    localparam logic [7:0] COS_IDX_SECOND_CTRL = 8'h1B;
    localparam logic [11:0] COS_ADDR_FIRST_CTRL = {2'h0, COS_IDX_FIRST_CTRL, 2'h0};
    localparam logic [11:0] COS_ADDR_SECOND_CTRL = {2'h0, COS_IDX_SECOND_CTRL, 2'h0};
    localparam logic [7:0] COS_FIRST_CTRL_RST = 8'h00;
    localparam logic [7:0] COS_SECOND_CTRL_RST = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int COS_SEL_LSB = 0;
    localparam int COS_SEL_MSB = 3;
    localparam int COS_LEVEL_BIT = 4;
    localparam int COS_CMI_EN_BIT = 5;
    localparam int COS_CMI_INV_BIT = 6;
    localparam int COS_TTL_BIT = 7;
    localparam int COS_NRZ_BIT = 7;
    localparam logic [7:0] COS_SECOND_WMASK = 8'h9F;

    // ****************************************
    // Function select codes
    // ****************************************
    typedef enum logic [3:0] {
        COS_FN_STATIC = 4'h0,
        COS_FN_RCLK = 4'h1,
        COS_FN_LOS = 4'h2,
        COS_FN_LOC = 4'h3,
        COS_FN_RAI = 4'h4,
        COS_FN_AIS = 4'h5,
        COS_FN_SLIP = 4'h6,
        COS_FN_CRCERR = 4'h7,
        COS_FN_LOTC = 4'h8,
        COS_FN_RFSYNC = 4'h9,
        COS_FN_PRBSERR = 4'hA,
        COS_FN_DATA = 4'hB,
        COS_FN_CRC4MF = 4'hC,
        COS_FN_CASMF = 4'hD,
        COS_FN_TCLIM = 4'hE,
        COS_FN_RAILS = 4'hF
    } cos_fn_t;

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic rclk;
        logic los;
        logic loc;
        logic rai;
        logic ais;
        logic slip;
        logic crc_err;
        logic lotc;
        logic rfsync;
        logic prbs_err;
        logic tdata;
        logic rdata;
        logic crc4_mf;
        logic cas_mf;
        logic tx_clim;
        logic tx_pos;
        logic tx_neg;
    } cos_src_t;

    typedef struct packed {
        logic ttl_rail_en;
        logic cmi_invert;
        logic cmi_en;
        logic nrz_en;
    } cos_rx_mode_t;

endpackage

// file: hw/cos_out_mux.sv
`timescale 1ns/100ps
module cos_out_mux
    import cos_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [7:0] i_ctrl,
    input wire cos_src_t i_src,
    input wire logic i_is_first,
    output logic o_pin
);

    // ****************************************
    // Selection
    // ****************************************
    wire cos_fn_t sel = cos_fn_t'(i_ctrl[COS_SEL_MSB:COS_SEL_LSB]);
    wire logic level = i_ctrl[COS_LEVEL_BIT];
    wire logic crc_gated = i_src.crc_err & ~i_src.los;
    wire logic data_bit = i_is_first ? i_src.rdata : i_src.tdata;
    wire logic rail_bit = i_is_first ? i_src.tx_neg : i_src.tx_pos;
    logic raw;
    logic pin_next;
    logic pin_reg;

    always_comb begin
        unique case (sel)
            COS_FN_STATIC: raw = 1'b0;
            COS_FN_RCLK: raw = i_src.rclk;
            COS_FN_LOS: raw = i_src.los;
            COS_FN_LOC: raw = i_src.loc;
            COS_FN_RAI: raw = i_src.rai;
            COS_FN_AIS: raw = i_src.ais;
            COS_FN_SLIP: raw = i_src.slip;
            COS_FN_CRCERR: raw = crc_gated;
            COS_FN_LOTC: raw = i_src.lotc;
            COS_FN_RFSYNC: raw = i_src.rfsync;
            COS_FN_PRBSERR: raw = i_src.prbs_err;
            COS_FN_DATA: raw = data_bit;
            COS_FN_CRC4MF: raw = i_src.crc4_mf;
            COS_FN_CASMF: raw = i_src.cas_mf;
            COS_FN_TCLIM: raw = i_src.tx_clim;
            COS_FN_RAILS: raw = rail_bit;
        endcase
    end

    // Static mode drives the level bit; otherwise a clear bit gives active low
    always_comb begin
        if (sel == COS_FN_STATIC) begin
            pin_next = level;
        end else begin
            pin_next = level ? raw : ~raw;
        end
    end

    // Registered so the pin never glitches while select bits change
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pin_reg <= 1'b0;
        end else begin
            pin_reg <= pin_next;
        end
    end

    assign o_pin = pin_reg;

endmodule

// file: hw/cos_top.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
module cos_top
    import cos_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire cos_src_t I_SRC,
    output cos_rx_mode_t O_RX_MODE,
    output logic O_GENERAL_OUTPUT_FIRST,
    output logic O_GENERAL_OUTPUT_SECOND
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire logic rst_b = rst_sync_reg;

    // ****************************************
    // APB decode
    // ****************************************
    logic [7:0] first_ctrl_reg;
    logic [7:0] second_ctrl_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    wire logic hit_a = (I_PADDR == COS_ADDR_FIRST_CTRL);
    wire logic hit_b = (I_PADDR == COS_ADDR_SECOND_CTRL);
    wire logic mapped = hit_a | hit_b;
    wire logic setup = I_PSEL & ~I_PENABLE;
    wire logic access = I_PSEL & I_PENABLE;
    wire logic wr_lane0 = access & I_PWRITE & I_PSTRB[0];
    wire logic wr_a = wr_lane0 & hit_a;
    wire logic wr_b = wr_lane0 & hit_b;
    // Unused bits 6:5 of the second register are held at zero whatever is written
    wire logic [7:0] second_wdata = I_PWDATA[7:0] & COS_SECOND_WMASK;

    assign prdata_next = hit_a ? {24'h000000, first_ctrl_reg} :
                         hit_b ? {24'h000000, second_ctrl_reg} : 32'h00000000;

    // Zero wait states: pready is high in every access phase
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = access & ~mapped;

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
        if (!rst_b) begin
            first_ctrl_reg <= COS_FIRST_CTRL_RST;
            second_ctrl_reg <= COS_SECOND_CTRL_RST;
        end else begin
            if (wr_a) begin
                first_ctrl_reg <= I_PWDATA[7:0];
            end
            if (wr_b) begin
                second_ctrl_reg <= second_wdata;
            end
        end
    end

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge I_CLK_SYS or negedge rst_b) begin
        if (!rst_b) begin
            prdata_reg <= 32'h00000000;
        end else if (setup & ~I_PWRITE) begin
            prdata_reg <= prdata_next;
        end
    end

    assign O_PRDATA = prdata_reg;

    // ****************************************
    // Receive line-input modes
    // ****************************************
    assign O_RX_MODE.ttl_rail_en = first_ctrl_reg[COS_TTL_BIT];
    assign O_RX_MODE.cmi_invert = first_ctrl_reg[COS_CMI_INV_BIT];
    assign O_RX_MODE.cmi_en = first_ctrl_reg[COS_CMI_EN_BIT];
    assign O_RX_MODE.nrz_en = second_ctrl_reg[COS_NRZ_BIT];

    // ****************************************
    // Output pins
    // ****************************************
    logic [7:0] ctrl_arr [2];
    logic [1:0] pins;

    assign ctrl_arr[0] = first_ctrl_reg;
    assign ctrl_arr[1] = second_ctrl_reg;

    // One independent mux per pin, each steered by its own register
    for (genvar g = 0; g < 2; g++) begin : g_out
        cos_out_mux u_mux (
            .i_clk(I_CLK_SYS),
            .i_rst_b(rst_b),
            .i_ctrl(ctrl_arr[g]),
            .i_src(I_SRC),
            .i_is_first(g == 0),
            .o_pin(pins[g])
        );
    end

    assign O_GENERAL_OUTPUT_FIRST = pins[0];
    assign O_GENERAL_OUTPUT_SECOND = pins[1];

endmodule

// file: dv/cos_top_props.sv
`timescale 1ns/100ps
// ****************************************
// Pin and mode checks seen from the ports
// ****************************************
module cos_top_props
    import cos_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_B,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic O_PREADY,
    input wire cos_src_t I_SRC,
    input wire cos_rx_mode_t O_RX_MODE,
    input wire logic O_GENERAL_OUTPUT_FIRST,
    input wire logic O_GENERAL_OUTPUT_SECOND
);
    logic [7:0] ra_reg;
    logic [7:0] rb_reg;
    // Shadow copies rebuilt from bus writes, since the real registers are hidden
    wire logic wr_en = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY && I_PSTRB[0];
    always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
        if (!I_RST_B) begin
            ra_reg <= 8'h00;
            rb_reg <= 8'h00;
        end else if (wr_en && I_PADDR == COS_ADDR_FIRST_CTRL) begin
            ra_reg <= I_PWDATA[7:0];
        end else if (wr_en && I_PADDR == COS_ADDR_SECOND_CTRL) begin
            rb_reg <= I_PWDATA[7:0] & COS_SECOND_WMASK;
        end
    end
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_B);
    sequence s_a(logic [3:0] c); ra_reg[3:0] == c; endsequence
    sequence s_b(logic [3:0] c); rb_reg[3:0] == c; endsequence
    AST_STA_A: assert property (s_a(4'h0) |=> O_GENERAL_OUTPUT_FIRST == $past(ra_reg[4])) else $error("static a");
    AST_STA_B: assert property (s_b(4'h0) |=> O_GENERAL_OUTPUT_SECOND == $past(rb_reg[4])) else $error("static b");
    AST_CLK_A: assert property (s_a(4'h1) |=>
        O_GENERAL_OUTPUT_FIRST == ($past(I_SRC.rclk) ~^ $past(ra_reg[4]))) else $error("clock a");
    AST_CLK_B: assert property (s_b(4'h1) |=>
        O_GENERAL_OUTPUT_SECOND == ($past(I_SRC.rclk) ~^ $past(rb_reg[4]))) else $error("clock b");
    AST_CRC_A: assert property (s_a(4'h7) ##0 I_SRC.los |=> O_GENERAL_OUTPUT_FIRST == !$past(ra_reg[4]))
        else $error("crc held");
    AST_DAT_A: assert property (s_a(4'hB) |=>
        O_GENERAL_OUTPUT_FIRST == ($past(I_SRC.rdata) ~^ $past(ra_reg[4]))) else $error("rx data");
    AST_RAIL_B: assert property (s_b(4'hF) |=>
        O_GENERAL_OUTPUT_SECOND == ($past(I_SRC.tx_pos) ~^ $past(rb_reg[4]))) else $error("pos rail");
    AST_MODE: assert property (O_RX_MODE == {ra_reg[7:5], rb_reg[7]}) else $error("rx mode");
endmodule
bind cos_top cos_top_props u_props (.I_CLK_SYS, .I_RST_B, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
    .I_PSTRB, .O_PREADY, .I_SRC, .O_RX_MODE, .O_GENERAL_OUTPUT_FIRST, .O_GENERAL_OUTPUT_SECOND);

// file: dv/cos_board_model.sv
`timescale 1ns/100ps
// ****************************************
// Board buffer on the two output pins
// ****************************************
module cos_board_model (
    input wire logic i_first,
    input wire logic i_second,
    output logic o_first,
    output logic o_second
);
    // The board only loads the pins, it never drives them back
    assign o_first = i_first;
    assign o_second = i_second;
endmodule

// file: dv/cos_top_tb.sv
`timescale 1ns/100ps
module cos_top_tb
    import cos_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, prd;
    logic [3:0] pst = 4'h0;
    logic prdy, perr, pa, pb, ba, bb;
    logic [7:0] sa = 8'h00, sb = 8'h00;
    cos_src_t src = '0;
    cos_rx_mode_t rxm;
    int err_count = 0, compares = 0;
    logic [1:0] q[$];
    initial forever #4 clk = ~clk;
    cos_top uut (.I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
        .I_PWDATA(pwd), .I_PSTRB(pst), .O_PRDATA(prd), .O_PREADY(prdy), .O_PSLVERR(perr), .I_SRC(src),
        .O_RX_MODE(rxm), .O_GENERAL_OUTPUT_FIRST(pa), .O_GENERAL_OUTPUT_SECOND(pb));
    cos_board_model board (.i_first(pa), .i_second(pb), .o_first(ba), .o_second(bb));
    // ****************************************
    // Expectations and comparison
    // ****************************************
    function automatic logic fpin(input logic [7:0] c, input cos_src_t s, input logic f);
        logic [15:0] r;
        r = {f ? s.tx_neg : s.tx_pos, s.tx_clim, s.cas_mf, s.crc4_mf, f ? s.rdata : s.tdata, s.prbs_err, s.rfsync,
            s.lotc, s.crc_err & ~s.los, s.slip, s.ais, s.rai, s.loc, s.los, s.rclk, 1'b1};
        return r[c[3:0]] ~^ c[4];
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) if (run) q.push_back({fpin(sa, src, 1'b1), fpin(sb, src, 1'b0)});
    // Pins are registered, so the note of one edge stands at the falling edge right after it
    always @(negedge clk) begin
        if (q.size() > 0) begin
            chk({ba, bb}, q.pop_front());
            chk(rxm, {sa[7:5], sb[7]});
        end
    end
    task step;
        @(posedge clk);
        src <= 17'($urandom);
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
        input logic [31:0] er, input logic ee);
        int n;
        step;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; padr <= a; pst <= s; pwd <= {24'($urandom), d};
        step;
        pen <= 1'b1;
        n = 0;
        do begin step; n++; end while (prdy !== 1'b1 && n < 50);
        if (n >= 50) err_count++;
        if (w && s[0] && a == COS_ADDR_FIRST_CTRL) sa <= d;
        if (w && s[0] && a == COS_ADDR_SECOND_CTRL) sb <= d & COS_SECOND_WMASK;
        if (!w) chk(prd, er);
        chk(perr, ee);
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task test_done;
        if (err_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] da, db;
        void'($urandom(32'h2EAEC140));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) step;
        run <= 1'b1;
        apb(1'b0, COS_ADDR_FIRST_CTRL, 8'h00, 4'h0, 32'h0, 1'b0);
        apb(1'b0, COS_ADDR_SECOND_CTRL, 8'h00, 4'h0, 32'h0, 1'b0);
        // Both pins sweep every code and level on different codes to show independence; the last two passes give both pins codes B then F
        for (int i = 0; i < 34; i++) begin
            da = (i > 31) ? ((i == 33) ? 8'h1F : 8'h0B) : {3'($urandom), i[4], i[3:0]};
            db = (i > 31) ? da : {1'($urandom), 2'b00, ~i[4], 4'hF - i[3:0]};
            apb(1'b1, COS_ADDR_FIRST_CTRL, da, 4'hF, 32'h0, 1'b0);
            apb(1'b1, COS_ADDR_SECOND_CTRL, db, 4'hF, 32'h0, 1'b0);
            repeat (20) step;
            apb(1'b0, COS_ADDR_FIRST_CTRL, 8'h00, 4'h0, {24'h0, da}, 1'b0);
            apb(1'b0, COS_ADDR_SECOND_CTRL, 8'h00, 4'h0, {24'h0, db}, 1'b0);
        end
        apb(1'b1, 12'h070, 8'hFF, 4'hF, 32'h0, 1'b1);
        apb(1'b0, 12'h070, 8'h00, 4'h0, 32'h0, 1'b1);
        apb(1'b1, COS_ADDR_FIRST_CTRL, 8'hE0, 4'h0, 32'h0, 1'b0);
        apb(1'b0, COS_ADDR_FIRST_CTRL, 8'h00, 4'h0, 32'h1F, 1'b0);
        repeat (4) step;
        test_done;
    end
    initial begin
        #100us;
        err_count++;
        $display("MISMATCH %0t timeout", $time);
        test_done;
    end
endmodule
